// ==== verilog/tsp_pkg.sv ====
// Purpose: Shared constants for the timer-shared PWM channel
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes:   Byte address is four times the register index

package tsp_pkg;

	// Register indices and byte addresses
	localparam int          TSP_ADDR_W    = 12;
	localparam logic [11:0] TSP_DUTY_IDX  = 12'h0314;
	localparam logic [11:0] TSP_CTL_IDX   = 12'h0316;
	localparam logic [11:0] TSP_DUTY_ADDR = {TSP_DUTY_IDX[9:0], 2'b00};
	localparam logic [11:0] TSP_CTL_ADDR  = {TSP_CTL_IDX[9:0], 2'b00};

	// Duty register fields
	localparam int TSP_DUTY_W      = 10;
	localparam int TSP_DUTY_MSB_LO = 8;
	localparam int TSP_DUTY_LSB_LO = 6;

	// Control register fields
	localparam int         TSP_CTL_EN_BIT  = 7;
	localparam int         TSP_CTL_OUT_BIT = 5;
	localparam int         TSP_CTL_INV_BIT = 4;
	localparam logic [7:0] TSP_CTL_RST     = 8'h00;

	// Bus responses
	localparam logic [1:0] TSP_RESP_OKAY   = 2'b00;
	localparam logic [1:0] TSP_RESP_SLVERR = 2'b10;

endpackage : tsp_pkg

// ==== verilog/tsp_axil_port.sv ====
// Purpose: AXI4-Lite slave handshake for the channel registers
// Assumes: One write and one read in flight at most
// Notes:   Address and data may arrive in either order

`timescale 1ns/1ps

module tsp_axil_port
#(
	parameter int ADDR_W = tsp_pkg::TSP_ADDR_W
)
(
	// Clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              reset_in,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	// Register side
	output logic                   wr_en_out,
	output logic [ADDR_W-1:0]      wr_addr_out,
	output logic [31:0]            wr_data_out,
	output logic [3:0]             wr_strb_out,
	input  wire logic              wr_ok_in,
	output logic                   rd_en_out,
	output logic [ADDR_W-1:0]      rd_addr_out,
	input  wire logic [31:0]       rd_data_in,
	input  wire logic              rd_ok_in
);
	import tsp_pkg::*;

	if (ADDR_W < TSP_ADDR_W)
	begin : g_chk
		$error("tsp_axil_port: ADDR_W too narrow");
	end

	typedef struct packed {
		logic              aw_h;
		logic [ADDR_W-1:0] aw_a;
		logic              w_h;
		logic [31:0]       w_d;
		logic [3:0]        w_s;
		logic              bv;
		logic [1:0]        br;
		logic              rv;
		logic [31:0]       rd;
		logic [1:0]        rr;
	} tsp_axil_st_t;

	tsp_axil_st_t st_r;
	tsp_axil_st_t st_nxt;

	assign s_axi_awready_out = !st_r.aw_h && !st_r.bv;
	assign s_axi_wready_out  = !st_r.w_h && !st_r.bv;
	assign s_axi_arready_out = !st_r.rv;
	assign s_axi_bvalid_out  = st_r.bv;
	assign s_axi_bresp_out   = st_r.br;
	assign s_axi_rvalid_out  = st_r.rv;
	assign s_axi_rdata_out   = st_r.rd;
	assign s_axi_rresp_out   = st_r.rr;
	assign wr_en_out         = st_r.aw_h && st_r.w_h && !st_r.bv;
	assign wr_addr_out       = st_r.aw_a;
	assign wr_data_out       = st_r.w_d;
	assign wr_strb_out       = st_r.w_s;
	assign rd_en_out         = s_axi_arvalid_in && !st_r.rv;
	assign rd_addr_out       = s_axi_araddr_in;

	always_comb
	begin
		st_nxt = st_r;
		if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			st_nxt.aw_h = 1'b1;
			st_nxt.aw_a = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			st_nxt.w_h = 1'b1;
			st_nxt.w_d = s_axi_wdata_in;
			st_nxt.w_s = s_axi_wstrb_in;
		end
		if (wr_en_out)
		begin
			st_nxt.aw_h = 1'b0;
			st_nxt.w_h  = 1'b0;
			st_nxt.bv   = 1'b1;
			st_nxt.br   = wr_ok_in ? TSP_RESP_OKAY : TSP_RESP_SLVERR;
		end
		else if (st_r.bv && s_axi_bready_in)
			st_nxt.bv = 1'b0;
		if (rd_en_out)
		begin
			st_nxt.rv = 1'b1;
			st_nxt.rd = rd_ok_in ? rd_data_in : 32'h0000_0000;
			st_nxt.rr = rd_ok_in ? TSP_RESP_OKAY : TSP_RESP_SLVERR;
		end
		else if (st_r.rv && s_axi_rready_in)
			st_nxt.rv = 1'b0;
		if (reset_in)
			st_nxt = '0;
	end

	always_ff @(posedge clk_sys_in)
		st_r <= st_nxt;

endmodule : tsp_axil_port

// ==== verilog/tsp_pwm_core.sv ====
// Purpose: Duty compare against the shared extended time base
// Assumes: Timer inputs come from logic on the same clock
// Notes:   Level is before polarity inversion

`timescale 1ns/1ps

module tsp_pwm_core
(
	// Clock and reset
	input  wire logic                          clk_sys_in,
	input  wire logic                          reset_in,
	// Shared time base
	input  wire logic [7:0]                    period_timer_count_in,
	input  wire logic [1:0]                    timer_sub_count_in,
	input  wire logic                          timer_tick_in,
	input  wire logic                          period_match_in,
	input  wire logic [7:0]                    period_register_in,
	// Channel control
	input  wire logic [tsp_pkg::TSP_DUTY_W-1:0] duty_in,
	input  wire logic                          enable_in,
	input  wire logic                          sleep_in,
	// Compare result
	output logic                               level_out,
	output logic [tsp_pkg::TSP_DUTY_W-1:0]     cmp_buf_out
);
	import tsp_pkg::*;

	typedef struct packed {
		logic [TSP_DUTY_W-1:0] cmp;
		logic                  lvl;
	} tsp_core_st_t;

	tsp_core_st_t          st_r;
	tsp_core_st_t          st_nxt;
	logic [TSP_DUTY_W-1:0] tbase;
	logic [TSP_DUTY_W:0]   limit;

	assign tbase       = {period_timer_count_in, timer_sub_count_in};
	assign limit       = {1'b0, period_register_in, 2'b00} + 11'h004;
	assign level_out   = st_r.lvl;
	assign cmp_buf_out = st_r.cmp;

	always_comb
	begin
		st_nxt = st_r;
		if (!sleep_in)
		begin
			if (timer_tick_in && period_match_in)
			begin
				st_nxt.cmp = duty_in;
				st_nxt.lvl = (duty_in != '0);
			end
			// Decided one count ahead, the level register adds a cycle
			else if ({1'b0, tbase} + 11'h001 == {1'b0, st_r.cmp} && {1'b0, st_r.cmp} < limit)
				st_nxt.lvl = 1'b0;
			if (!enable_in)
				st_nxt.lvl = 1'b0;
		end
		if (reset_in)
			st_nxt = '0;
	end

	always_ff @(posedge clk_sys_in)
		st_r <= st_nxt;

endmodule : tsp_pwm_core

// ==== verilog/tsp_channel.sv ====
// Purpose: One PWM channel on a shared period timer, AXI4-Lite registers
// Assumes: Timer, period register and pin direction live outside
// Notes:   Duty bytes survive reset; control returns to zero
//
// Contract
// - Duty is high byte plus bits 7:6
// - Duty bytes writable at any time
// - High time is duty times sub-count period
// - Time base is timer count plus sub-count
// - Resolution follows four times period plus one
// - Overlong pulse width leaves pin unchanged
// - Sleep freezes level, compare buffer and pin; pin enable still follows direction
// - Counting resumes from frozen value after wake
// - Output rate follows the system clock
// - Any reset restores control registers
// - Output muxed with port latch, direction gated
// - Control bit 7 enables the channel
// - Control bit 5 reads output level
// - Control bit 4 inverts the output
// - Duty bits untouched by reset
// - Set at restart, clear on duty match
// - Duty at or above period: never cleared
// - Duty buffered, loaded at period match
// - Zero duty stays inactive through restart

`timescale 1ns/1ps

module tsp_channel
#(
	parameter int ADDR_W = tsp_pkg::TSP_ADDR_W
)
(
	// Clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              reset_in,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	// Shared period timer
	input  wire logic [7:0]        period_timer_count_in,
	input  wire logic [1:0]        timer_sub_count_in,
	input  wire logic              timer_tick_in,
	input  wire logic              period_match_in,
	input  wire logic [7:0]        period_register_in,
	// Device state and port
	input  wire logic              sleep_in,
	input  wire logic              port_latch_in,
	input  wire logic              pin_direction_in,
	// Outputs
	output logic                   pwm_level_out,
	output logic                   pin_out,
	output logic                   pin_oe_out
);
	import tsp_pkg::*;

	if (ADDR_W < TSP_ADDR_W)
	begin : g_chk
		$error("tsp_channel: ADDR_W too narrow");
	end

	typedef struct packed {
		logic [7:0] duty_msbs;
		logic [1:0] duty_lsbs;
		logic       en;
		logic       inv;
		logic       pin;
		logic       oe;
	} tsp_top_st_t;

	tsp_top_st_t           st_r;
	tsp_top_st_t           st_nxt;
	logic                  wr_en;
	logic [ADDR_W-1:0]     wr_addr;
	logic [31:0]           wr_data;
	logic [3:0]            wr_strb;
	logic                  wr_ok;
	logic                  rd_en;
	logic [ADDR_W-1:0]     rd_addr;
	logic [31:0]           rd_data;
	logic                  rd_ok;
	logic                  hit_duty_w;
	logic                  hit_ctl_w;
	logic                  core_lvl;
	logic [TSP_DUTY_W-1:0] core_buf;
	logic [TSP_DUTY_W-1:0] duty;

	tsp_axil_port #(
		.ADDR_W (ADDR_W)
	) u_port (
		.clk_sys_in        (clk_sys_in),
		.reset_in          (reset_in),
		.s_axi_awaddr_in   (s_axi_awaddr_in),
		.s_axi_awvalid_in  (s_axi_awvalid_in),
		.s_axi_awready_out (s_axi_awready_out),
		.s_axi_wdata_in    (s_axi_wdata_in),
		.s_axi_wstrb_in    (s_axi_wstrb_in),
		.s_axi_wvalid_in   (s_axi_wvalid_in),
		.s_axi_wready_out  (s_axi_wready_out),
		.s_axi_bresp_out   (s_axi_bresp_out),
		.s_axi_bvalid_out  (s_axi_bvalid_out),
		.s_axi_bready_in   (s_axi_bready_in),
		.s_axi_araddr_in   (s_axi_araddr_in),
		.s_axi_arvalid_in  (s_axi_arvalid_in),
		.s_axi_arready_out (s_axi_arready_out),
		.s_axi_rdata_out   (s_axi_rdata_out),
		.s_axi_rresp_out   (s_axi_rresp_out),
		.s_axi_rvalid_out  (s_axi_rvalid_out),
		.s_axi_rready_in   (s_axi_rready_in),
		.wr_en_out         (wr_en),
		.wr_addr_out       (wr_addr),
		.wr_data_out       (wr_data),
		.wr_strb_out       (wr_strb),
		.wr_ok_in          (wr_ok),
		.rd_en_out         (rd_en),
		.rd_addr_out       (rd_addr),
		.rd_data_in        (rd_data),
		.rd_ok_in          (rd_ok)
	);

	assign duty = {st_r.duty_msbs, st_r.duty_lsbs};

	tsp_pwm_core u_core (
		.clk_sys_in            (clk_sys_in),
		.reset_in              (reset_in),
		.period_timer_count_in (period_timer_count_in),
		.timer_sub_count_in    (timer_sub_count_in),
		.timer_tick_in         (timer_tick_in),
		.period_match_in       (period_match_in),
		.period_register_in    (period_register_in),
		.duty_in               (duty),
		.enable_in             (st_r.en),
		.sleep_in              (sleep_in),
		.level_out             (core_lvl),
		.cmp_buf_out           (core_buf)
	);

	// Address decode
	assign hit_duty_w = (wr_addr == ADDR_W'(TSP_DUTY_ADDR));
	assign hit_ctl_w  = (wr_addr == ADDR_W'(TSP_CTL_ADDR));
	assign wr_ok      = hit_duty_w || hit_ctl_w;
	assign rd_ok      = (rd_addr == ADDR_W'(TSP_DUTY_ADDR)) || (rd_addr == ADDR_W'(TSP_CTL_ADDR));

	// Polarity after compare
	assign pwm_level_out = core_lvl ^ st_r.inv;
	assign pin_out       = st_r.pin;
	assign pin_oe_out    = st_r.oe;

	// Read mux; unused bits read zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (rd_addr == ADDR_W'(TSP_DUTY_ADDR))
		begin
			rd_data[TSP_DUTY_MSB_LO +: 8] = st_r.duty_msbs;
			rd_data[TSP_DUTY_LSB_LO +: 2] = st_r.duty_lsbs;
		end
		else if (rd_addr == ADDR_W'(TSP_CTL_ADDR))
		begin
			rd_data[TSP_CTL_EN_BIT]  = st_r.en;
			rd_data[TSP_CTL_OUT_BIT] = pwm_level_out;
			rd_data[TSP_CTL_INV_BIT] = st_r.inv;
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		if (wr_en && hit_duty_w && !reset_in)
		begin
			if (wr_strb[1])
				st_nxt.duty_msbs = wr_data[TSP_DUTY_MSB_LO +: 8];
			if (wr_strb[0])
				st_nxt.duty_lsbs = wr_data[TSP_DUTY_LSB_LO +: 2];
		end
		if (wr_en && hit_ctl_w && wr_strb[0] && !reset_in)
		begin
			st_nxt.en  = wr_data[TSP_CTL_EN_BIT];
			st_nxt.inv = wr_data[TSP_CTL_INV_BIT];
		end
		// Pin mux; held while asleep
		if (!sleep_in)
			st_nxt.pin = st_r.en ? pwm_level_out : port_latch_in;
		st_nxt.oe = !pin_direction_in;
		if (reset_in)
		begin
			st_nxt.en  = TSP_CTL_RST[TSP_CTL_EN_BIT];
			st_nxt.inv = TSP_CTL_RST[TSP_CTL_INV_BIT];
			st_nxt.pin = 1'b0;
			st_nxt.oe  = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in)
		st_r <= st_nxt;

	// Checks
	logic [TSP_DUTY_W-1:0] tbase_chk;
	logic [TSP_DUTY_W:0]   limit_chk;
	logic                  restart_chk;

	assign tbase_chk   = {period_timer_count_in, timer_sub_count_in};
	assign limit_chk   = {1'b0, period_register_in, 2'b00} + 11'h004;
	assign restart_chk = timer_tick_in && period_match_in && !sleep_in;

	property p_disable_low;
		@(posedge clk_sys_in) disable iff (reset_in)
		!st_r.en && !sleep_in |=> !core_lvl;
	endproperty
	a_disable_low: assert property (p_disable_low)
		else $error("Disabled channel drove a high level");

	property p_buffer_load;
		@(posedge clk_sys_in) disable iff (reset_in)
		restart_chk |=> core_buf == $past(duty);
	endproperty
	a_buffer_load: assert property (p_buffer_load)
		else $error("Compare buffer not loaded at period match");

	property p_buffer_hold;
		@(posedge clk_sys_in) disable iff (reset_in)
		!(timer_tick_in && period_match_in) |=> $stable(core_buf);
	endproperty
	a_buffer_hold: assert property (p_buffer_hold)
		else $error("Compare buffer changed outside period match");

	property p_zero_duty;
		@(posedge clk_sys_in) disable iff (reset_in)
		restart_chk && st_r.en && duty == '0 |=> !core_lvl ##1 !core_lvl || restart_chk;
	endproperty
	a_zero_duty: assert property (p_zero_duty)
		else $error("Zero duty asserted the output at restart");

	property p_restart_set;
		@(posedge clk_sys_in) disable iff (reset_in)
		restart_chk && st_r.en && duty != '0 |=> core_lvl;
	endproperty
	a_restart_set: assert property (p_restart_set)
		else $error("Output not set at period restart");

	property p_match_clear;
		@(posedge clk_sys_in) disable iff (reset_in)
		!sleep_in && !(timer_tick_in && period_match_in) && {1'b0, tbase_chk} + 11'h001 == {1'b0, core_buf}
			&& {1'b0, core_buf} < limit_chk && core_lvl |=> !core_lvl;
	endproperty
	a_match_clear: assert property (p_match_clear)
		else $error("Output not cleared on duty match");

	property p_full_duty;
		@(posedge clk_sys_in) disable iff (reset_in)
		st_r.en && st_nxt.en && !restart_chk && {1'b0, core_buf} >= limit_chk && core_lvl |=> core_lvl;
	endproperty
	a_full_duty: assert property (p_full_duty)
		else $error("Output cleared with duty beyond period");

	property p_sleep_freeze;
		@(posedge clk_sys_in) disable iff (reset_in)
		sleep_in |=> $stable(core_lvl) && $stable(core_buf) && $stable(st_r.pin);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze)
		else $error("Channel state moved during sleep");

	property p_pin_mux;
		@(posedge clk_sys_in) disable iff (reset_in)
		!reset_in && !sleep_in |=> pin_out == ($past(st_r.en) ? $past(pwm_level_out) : $past(port_latch_in));
	endproperty
	a_pin_mux: assert property (p_pin_mux)
		else $error("Pin value does not follow the output mux");

	property p_reset_ctl;
		@(posedge clk_sys_in)
		reset_in |=> !st_r.en && !st_r.inv && !core_lvl && !pin_oe_out;
	endproperty
	a_reset_ctl: assert property (p_reset_ctl)
		else $error("Control not cleared by reset");

	property p_duty_write;
		@(posedge clk_sys_in) disable iff (reset_in)
		wr_en && hit_duty_w && wr_strb[1] |=> st_r.duty_msbs == $past(wr_data[15:8]);
	endproperty
	a_duty_write: assert property (p_duty_write)
		else $error("Duty write was not stored");

	property p_duty_lsb_write;
		@(posedge clk_sys_in) disable iff (reset_in)
		wr_en && hit_duty_w && wr_strb[0] |=> st_r.duty_lsbs == $past(wr_data[7:6]);
	endproperty
	a_duty_lsb_write: assert property (p_duty_lsb_write)
		else $error("Duty low bits were not stored");

	property p_ctl_write;
		@(posedge clk_sys_in) disable iff (reset_in)
		wr_en && hit_ctl_w && wr_strb[0] |=> st_r.en == $past(wr_data[7]) && st_r.inv == $past(wr_data[4]);
	endproperty
	a_ctl_write: assert property (p_ctl_write)
		else $error("Control write was not stored");

	property p_status_read;
		@(posedge clk_sys_in) disable iff (reset_in)
		rd_en && rd_addr == ADDR_W'(TSP_CTL_ADDR) |=> s_axi_rdata_out[5] == $past(pwm_level_out);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("Status bit does not show the output level");

	property p_pin_oe;
		@(posedge clk_sys_in) disable iff (reset_in)
		!reset_in |=> pin_oe_out == !$past(pin_direction_in);
	endproperty
	a_pin_oe: assert property (p_pin_oe)
		else $error("Pin driver enable does not follow direction");

	property p_rise_at_restart;
		@(posedge clk_sys_in) disable iff (reset_in)
		!core_lvl && !restart_chk |=> !core_lvl;
	endproperty
	a_rise_at_restart: assert property (p_rise_at_restart)
		else $error("Output rose away from period restart");

	property p_rdata_hold;
		@(posedge clk_sys_in) disable iff (reset_in)
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("Read data moved before it was taken");

endmodule : tsp_channel

// ==== verification/tsp_timer_model.sv ====
// Purpose: Shared period timer model for the channel bench
// Assumes: Prescale 1:1, timer clocked at a quarter of the system clock
// Notes:   Count restarts on the tick after a period match
`timescale 1ns/1ps
module tsp_timer_model
(
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       reset_in,
	// Control
	input  wire logic       sleep_in,
	input  wire logic [7:0] period_register_in,
	// Time base
	output logic [7:0]      count_out,
	output logic [1:0]      sub_out,
	output logic            tick_out,
	output logic            match_out
);
	assign tick_out  = (sub_out == 2'h3) && !sleep_in;
	assign match_out = (count_out == period_register_in);
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			count_out <= 8'h00;
			sub_out   <= 2'h0;
		end
		else if (!sleep_in)
		begin
			sub_out <= sub_out + 2'h1;
			if (tick_out)
				count_out <= match_out ? 8'h00 : count_out + 8'h01;
		end
	end
endmodule : tsp_timer_model

// ==== verification/tsp_channel_tb.sv ====
// Purpose: Self-checking bench for the timer-shared PWM channel
// Assumes: Timer model at prescale 1:1 drives the shared time base
// Notes:   High time is counted over one full period in steady state
`timescale 1ns/1ps
module tsp_channel_tb;
	import tsp_pkg::*;
	logic        clk_sys_in, reset_in, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, junk;
	logic [1:0]  bresp, rresp, rsp, sub;
	logic [3:0]  wstrb;
	logic [7:0]  count, per;
	logic        tick, match, sleep, latch, dir, level, pin, pin_oe, lv;
	int          n_mismatch, n_tests, k, dv, pr;
	int          cd[6] = '{0, 0, 32, 1023, 5, 3};
	int          cp[6] = '{7, 7, 7, 255, 0, 0};
	logic        ci[6] = '{0, 1, 0, 0, 1, 0};

	tsp_channel DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .period_timer_count_in(count),
		.timer_sub_count_in(sub), .timer_tick_in(tick), .period_match_in(match),
		.period_register_in(per), .sleep_in(sleep), .port_latch_in(latch),
		.pin_direction_in(dir), .pwm_level_out(level), .pin_out(pin), .pin_oe_out(pin_oe));

	tsp_timer_model TMR (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .sleep_in(sleep),
		.period_register_in(per), .count_out(count), .sub_out(sub), .tick_out(tick),
		.match_out(match));

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic tally_and_finish;
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic tmo;
		chk(32'h0, 32'h1, "wait ran out");
		tally_and_finish();
	endtask : tmo

	task automatic axw(input logic [11:0] a, input logic [31:0] dt, output logic [1:0] r);
		awaddr  <= a;
		wdata   <= dt;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk_sys_in);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				@(posedge clk_sys_in);
				return;
			end
		end
		tmo();
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk_sys_in);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				dt = rdata;
				r = rresp;
				rready <= 1'b0;
				@(posedge clk_sys_in);
				return;
			end
		end
		tmo();
	endtask : axr

	task automatic wait_restart;
		for (int i = 0; i < 5000; i++)
		begin
			@(posedge clk_sys_in);
			if (tick && match)
				return;
		end
		tmo();
	endtask : wait_restart

	task automatic wait_tb(input logic [9:0] v);
		for (int i = 0; i < 5000; i++)
		begin
			@(posedge clk_sys_in);
			if ({count, sub} == v)
				return;
		end
		tmo();
	endtask : wait_tb

	function automatic int exp_high(input int d, input int p, input logic iv);
		int pp;
		int hh;
		pp = 4 * (p + 1);
		hh = (d >= pp) ? pp : d;
		return iv ? pp - hh : hh;
	endfunction : exp_high

	// Setup order, readback, then high time over one period
	task automatic run(input int d, input int p, input logic iv);
		int h;
		h = 0;
		junk = $urandom;
		axw(TSP_CTL_ADDR, 32'h0, rsp);
		per <= 8'(p);
		axw(TSP_DUTY_ADDR, {junk[31:16], 10'(d), junk[5:0]}, rsp);
		chk(32'(rsp), 32'(TSP_RESP_OKAY), "duty write resp");
		axr(TSP_DUTY_ADDR, rd, rsp);
		chk(rd, {16'h0, 10'(d), 6'h0}, "duty readback");
		wait_restart();
		axw(TSP_CTL_ADDR, {24'h0, 1'b1, 2'b0, iv, 4'h0}, rsp);
		axr(TSP_CTL_ADDR, rd, rsp);
		chk(rd & 32'hFFFF_FFDF, {24'h0, 1'b1, 2'b0, iv, 4'h0}, "control readback");
		wait_restart();
		wait_restart();
		for (int i = 0; i < 4 * (p + 1); i++)
		begin
			@(posedge clk_sys_in);
			h += int'(level === 1'b1);
		end
		chk(32'(h), 32'(exp_high(d, p, iv)), "high time");
	endtask : run

	initial
	begin
		reset_in = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, sleep} = '0;
		// Long first period, so duty is defined before the first restart
		{awaddr, araddr, wdata, per, wstrb} = {56'h0, 8'hFF, 4'hF};
		dir = 1'b1;
		n_mismatch = 0;
		n_tests = 0;
		k = $urandom(32'h77fdab19);
		latch = 1'($urandom);
		repeat (12) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
		axw(TSP_DUTY_ADDR, 32'h0, rsp);
		axr(TSP_CTL_ADDR, rd, rsp);
		chk(rd, 32'h0, "control reset");
		axw(12'h004, 32'hFFFF_FFFF, rsp);
		chk(32'(rsp), 32'(TSP_RESP_SLVERR), "unmapped write");
		axr(12'h004, rd, rsp);
		chk(rd, 32'h0, "unmapped read data");
		chk(32'(rsp), 32'(TSP_RESP_SLVERR), "unmapped read resp");
		for (k = 0; k < 6; k++)
			run(cd[k], cp[k], ci[k]);
		for (k = 0; k < 8; k++)
		begin
			pr = $urandom_range(15);
			dv = $urandom_range(4 * (pr + 1) + 3);
			run(dv, pr, 1'($urandom));
		end
		// Buffered duty only takes effect at restart
		run(800, 255, 1'b0);
		wait_restart();
		axw(TSP_DUTY_ADDR, {16'h0, 10'd100, 6'h0}, rsp);
		wait_tb(10'd300);
		chk(32'(level), 32'h1, "old duty kept");
		wait_restart();
		wait_tb(10'd300);
		chk(32'(level), 32'h0, "new duty loaded");
		// Sleep freezes the level mid-pulse, wake resumes
		run(20, 15, 1'b0);
		wait_restart();
		repeat (2) @(posedge clk_sys_in);
		sleep <= 1'b1;
		repeat (60) @(posedge clk_sys_in);
		chk(32'(level), 32'h1, "sleep froze");
		sleep <= 1'b0;
		repeat (30) @(posedge clk_sys_in);
		chk(32'(level), 32'h0, "resumed after wake");
		// Status bit and pin multiplexing
		run(0, 7, 1'b1);
		dir <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		axr(TSP_CTL_ADDR, rd, rsp);
		chk(32'(rd[5]), 32'h1, "status level");
		chk({31'h0, pin}, 32'h1, "pin carries pwm");
		chk({31'h0, pin_oe}, 32'h1, "pin driven");
		axw(TSP_CTL_ADDR, 32'h0, rsp);
		repeat (3) @(posedge clk_sys_in);
		chk({31'h0, pin}, {31'h0, latch}, "pin carries latch");
		// Byte strobes, then reset mid-run keeps duty, clears control
		axw(TSP_DUTY_ADDR, 32'h0000_A5C0, rsp);
		wstrb <= 4'h2;
		axw(TSP_DUTY_ADDR, 32'h0000_3A00, rsp);
		wstrb <= 4'hF;
		axw(TSP_CTL_ADDR, 32'h0000_0090, rsp);
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
		axr(TSP_CTL_ADDR, rd, rsp);
		chk(rd, 32'h0, "control after reset");
		axr(TSP_DUTY_ADDR, rd, rsp);
		chk(rd, 32'h0000_3AC0, "duty kept over reset");
		tally_and_finish();
	end
endmodule : tsp_channel_tb
